// ### core/mqf_front_end.v
// modbus tcp query front end: gear query, relay status, event log, exceptions, upgrade leds
`timescale 1ns/1ps
`default_nettype none
`include "mqf_map.vh"

module mqf_front_end #(
	parameter LED_HALF_CYC = `MQF_LED_HALF_MS * `MQF_CLK_KHZ,
	parameter EV_AW        = `MQF_EVENT_DEPTH_LOG2
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire        ce,
	input  wire [7:0]  rx_data,
	input  wire        rx_valid,
	input  wire        rx_last,
	output reg         rx_ready_r,
	output reg  [7:0]  tx_data_r,
	output reg         tx_valid_r,
	output reg         tx_last_r,
	input  wire        tx_ready,
	output reg         gear_req_valid_r,
	output reg  [31:0] gear_req_data_r,
	input  wire        gear_res_valid,
	input  wire [63:0] gear_res_data,
	input  wire [3:0]  relay_closed,
	input  wire        evt_valid,
	input  wire [5:0]  evt_dev_addr,
	input  wire [7:0]  evt_inst,
	input  wire [7:0]  evt_type,
	input  wire [7:0]  evt_info,
	input  wire        set_button,
	input  wire        usb_upg_start,
	input  wire        usb_upg_done,
	output reg         led_bus_a_r,
	output reg         led_bus_b_r,
	output reg         sys_restart_r
);
	localparam ST_IDLE   = 3'd0;
	localparam ST_DECODE = 3'd1;
	localparam ST_GEAR   = 3'd2;
	localparam ST_MEMRD  = 3'd3;
	localparam ST_MEMLD  = 3'd4;
	localparam ST_SEND   = 3'd5;
	reg [2:0]       state_r;
	reg [7:0]       rxb [0:20];
	reg [4:0]       rx_cnt_r;
	reg             rx_ovf_r;
	reg [15:0]      tid_r;
	reg [15:0]      pid_r;
	reg [7:0]       unit_r;
	reg [7:0]       fn_r;
	reg [7:0]       len_r;
	reg [7:0]       b8_r;
	reg [63:0]      payload_r;
	reg [4:0]       tx_idx_r;
	reg [EV_AW-1:0] rd_idx_r;
	reg [EV_AW-1:0] wr_ptr_r;
	wire [31:0]     ev_rdata;
	// pins from outside the clock domain: two flops before use; the event write pointer rides along
	reg [3:0]  relay_s1_r, relay_s2_r;
	reg        btn_s1_r, btn_s2_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			relay_s1_r <= 4'h0;
			relay_s2_r <= 4'h0;
			btn_s1_r   <= 1'b0;
			btn_s2_r   <= 1'b0;
			wr_ptr_r   <= {EV_AW{1'b0}};
		end else if (ce) begin
			relay_s1_r <= relay_closed;
			relay_s2_r <= relay_s1_r;
			btn_s1_r   <= set_button;
			btn_s2_r   <= btn_s1_r;
			// event log: pointer wraps from record 127 back to record 0
			if (evt_valid)
				wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end
	mqf_event_mem #(.AW(EV_AW), .DW(32)) mqf_event_mem_i (
		.clk     (clk),
		.ce      (ce),
		.we      (evt_valid),
		.waddr   (wr_ptr_r),
		.wdata   ({2'b00, evt_dev_addr, evt_inst, evt_type, evt_info}),
		.raddr   (rd_idx_r),
		.rdata_r (ev_rdata)
	);
	// request field views over the receive buffer
	wire [7:0]  rq_fn    = rxb[7];
	wire [15:0] rq_len   = {rxb[4], rxb[5]};
	wire [15:0] rq_addr  = {rxb[8], rxb[9]};
	wire [15:0] rq_qty   = {rxb[10], rxb[11]};
	wire [15:0] rq_waddr = {rxb[12], rxb[13]};
	wire [15:0] rq_wqty  = {rxb[14], rxb[15]};
	wire [15:0] ev_ofs   = rq_addr - `MQF_EVENT_LOG_ADDR;
	wire        len_ok   = !rx_ovf_r && (rq_len == {11'h000, rx_cnt_r - `MQF_MBAP_FIXED});
	wire        is_relay = (rx_cnt_r == `MQF_FN3_FRAME_LEN) && (rq_addr == `MQF_RELAY_STATE_ADDR)
	                       && (rq_qty == `MQF_RELAY_QTY);
	wire        is_event = (rx_cnt_r == `MQF_FN3_FRAME_LEN) && (rq_addr >= `MQF_EVENT_LOG_ADDR)
	                       && (ev_ofs <= `MQF_EVENT_LAST_OFS) && !ev_ofs[0] && (rq_qty == `MQF_EVENT_QTY);
	wire        is_gear  = (rx_cnt_r == `MQF_FN17_FRAME_LEN) && (rq_addr == `MQF_GEAR_RESULT_ADDR)
	                       && (rq_qty == `MQF_GEAR_RESULT_QTY) && (rq_waddr == `MQF_GEAR_REQUEST_ADDR)
	                       && (rq_wqty == `MQF_GEAR_REQUEST_QTY) && (rxb[16] == `MQF_GEAR_REQ_BYTES);
	// relay i takes the high byte of its register, relay one leads
	wire [63:0] relay_pay = {7'h00, relay_s2_r[0], 8'h00, 7'h00, relay_s2_r[1], 8'h00,
	                         7'h00, relay_s2_r[2], 8'h00, 7'h00, relay_s2_r[3], 8'h00};
	// outgoing byte: mbap echo, function, count or exception code, then payload
	wire [4:0]  tot_len = len_r[4:0] + `MQF_MBAP_FIXED;
	wire [4:0]  pay_k   = tx_idx_r - 5'd9;
	wire [63:0] pay_sh  = payload_r << {pay_k[2:0], 3'b000};
	reg  [7:0]  tx_byte;
	always @* begin
		case (tx_idx_r)
			5'd0: tx_byte = tid_r[15:8];
			5'd1: tx_byte = tid_r[7:0];
			5'd2: tx_byte = pid_r[15:8];
			5'd3: tx_byte = pid_r[7:0];
			5'd4: tx_byte = 8'h00;
			5'd5: tx_byte = len_r;
			5'd6: tx_byte = unit_r;
			5'd7: tx_byte = fn_r;
			5'd8: tx_byte = b8_r;
			default: tx_byte = pay_sh[63:56];
		endcase
	end
	// request collection, decode, answer sequencing
	integer i;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r          <= ST_IDLE;
			rx_cnt_r         <= 5'd0;
			rx_ovf_r         <= 1'b0;
			rx_ready_r       <= 1'b0;
			tid_r            <= 16'h0000;
			pid_r            <= 16'h0000;
			unit_r           <= 8'h00;
			fn_r             <= 8'h00;
			len_r            <= 8'h00;
			b8_r             <= 8'h00;
			payload_r        <= 64'h0;
			tx_idx_r         <= 5'd0;
			rd_idx_r         <= {EV_AW{1'b0}};
			tx_data_r        <= 8'h00;
			tx_valid_r       <= 1'b0;
			tx_last_r        <= 1'b0;
			gear_req_valid_r <= 1'b0;
			gear_req_data_r  <= 32'h0;
			for (i = 0; i < 21; i = i + 1)
				rxb[i] <= 8'h00;
		end else if (ce) begin
			gear_req_valid_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					rx_ready_r <= 1'b1;
					if (rx_valid && rx_ready_r) begin
						// bytes past the longest legal frame only mark the frame bad
						if (rx_cnt_r < `MQF_RX_MAX) begin
							rxb[rx_cnt_r] <= rx_data;
							rx_cnt_r      <= rx_cnt_r + 5'd1;
						end else begin
							rx_ovf_r <= 1'b1;
						end
						if (rx_last) begin
							rx_ready_r <= 1'b0;
							state_r    <= ST_DECODE;
						end
					end
				end
				ST_DECODE: begin
					tid_r    <= {rxb[0], rxb[1]};
					pid_r    <= {rxb[2], rxb[3]};
					unit_r   <= rxb[6];
					tx_idx_r <= 5'd0;
					rx_cnt_r <= 5'd0;
					rx_ovf_r <= 1'b0;
					state_r  <= ST_SEND;
					// too short to carry a function code: dropped without reply
					if (rx_cnt_r < 5'd8 && !rx_ovf_r) begin
						state_r <= ST_IDLE;
					end else if (rq_fn != `MQF_FN_READ_HOLD && rq_fn != `MQF_FN_RW_MULTI) begin
						fn_r  <= rq_fn | `MQF_FN_ERR_FLAG;
						b8_r  <= `MQF_EXC_BAD_FUNC;
						len_r <= `MQF_LEN_ERROR;
					end else if (!len_ok || !(is_gear || is_relay || is_event)
					             || (rq_fn == `MQF_FN_RW_MULTI) != is_gear) begin
						fn_r  <= rq_fn | `MQF_FN_ERR_FLAG;
						b8_r  <= `MQF_EXC_BAD_DATA;
						len_r <= `MQF_LEN_ERROR;
					end else if (is_gear) begin
						fn_r             <= `MQF_FN_RW_MULTI;
						b8_r             <= `MQF_BC_EIGHT;
						len_r            <= `MQF_LEN_GEAR;
						gear_req_data_r  <= {rxb[17], rxb[18], rxb[19], rxb[20]};
						gear_req_valid_r <= 1'b1;
						state_r          <= ST_GEAR;
					end else if (is_relay) begin
						fn_r      <= `MQF_FN_READ_HOLD;
						b8_r      <= `MQF_BC_EIGHT;
						len_r     <= `MQF_LEN_RELAY;
						payload_r <= relay_pay;
					end else begin
						fn_r     <= `MQF_FN_READ_HOLD;
						b8_r     <= `MQF_BC_FOUR;
						len_r    <= `MQF_LEN_EVENT;
						rd_idx_r <= ev_ofs[EV_AW:1];
						state_r  <= ST_MEMRD;
					end
				end
				ST_GEAR: begin
					// wait for the gear side to hand back the four result registers
					if (gear_res_valid) begin
						payload_r <= gear_res_data;
						state_r   <= ST_SEND;
					end
				end
				ST_MEMRD: state_r <= ST_MEMLD; // ram read data appear one edge later
				ST_MEMLD: begin
					payload_r <= {ev_rdata, 32'h0};
					state_r   <= ST_SEND;
				end
				ST_SEND: begin
					if (!tx_valid_r || tx_ready) begin
						if (tx_idx_r < tot_len) begin
							tx_data_r  <= tx_byte;
							tx_valid_r <= 1'b1;
							tx_last_r  <= (tx_idx_r == tot_len - 5'd1);
							tx_idx_r   <= tx_idx_r + 5'd1;
						end else begin
							tx_valid_r <= 1'b0;
							tx_last_r  <= 1'b0;
							state_r    <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	// upgrade mode: button caught once synchronised; only usb events drive it, never a modbus function
	reg [1:0]  cap_cnt_r;
	reg        upg_mode_r;
	reg [23:0] led_cnt_r;
	reg        led_ph_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cap_cnt_r     <= 2'd0;
			upg_mode_r    <= 1'b0;
			led_cnt_r     <= 24'h0;
			led_ph_r      <= 1'b0;
			led_bus_a_r   <= 1'b0;
			led_bus_b_r   <= 1'b0;
			sys_restart_r <= 1'b0;
		end else if (ce) begin
			sys_restart_r <= 1'b0;
			if (cap_cnt_r != 2'd3) begin
				cap_cnt_r <= cap_cnt_r + 2'd1;
				if (cap_cnt_r == 2'd2)
					upg_mode_r <= btn_s2_r;
			end
			if (upg_mode_r && usb_upg_done) begin
				upg_mode_r    <= 1'b0;
				sys_restart_r <= 1'b1;
			end else if (upg_mode_r && usb_upg_start) begin
				led_cnt_r <= 24'h0;
				led_ph_r  <= 1'b0;
			end else if (upg_mode_r) begin
				if (led_cnt_r == LED_HALF_CYC[23:0] - 24'h1) begin
					led_cnt_r <= 24'h0;
					led_ph_r  <= ~led_ph_r;
				end else begin
					led_cnt_r <= led_cnt_r + 24'h1;
				end
			end
			// leds alternate only in upgrade mode; a start shows the restarted phase at once, not a cycle late
			led_bus_a_r <= upg_mode_r && !usb_upg_done && !usb_upg_start && led_ph_r;
			led_bus_b_r <= upg_mode_r && !usb_upg_done && (usb_upg_start || !led_ph_r);
		end
	end

endmodule // mqf_front_end

`default_nettype wire

// ### core/mqf_map.vh
// register window addresses, function codes, field values and timing of the query front end
`ifndef MQF_MAP_VH
`define MQF_MAP_VH

// register windows (protocol addresses carried in the request pdu)
`define MQF_GEAR_RESULT_ADDR   16'h7d01
`define MQF_RELAY_STATE_ADDR   16'h80e9
`define MQF_EVENT_LOG_ADDR     16'h84d2
`define MQF_GEAR_REQUEST_ADDR  16'ha411

// register counts and byte counts per window
`define MQF_GEAR_RESULT_QTY    16'h0004
`define MQF_GEAR_REQUEST_QTY   16'h0002
`define MQF_GEAR_REQ_BYTES     8'h04
`define MQF_RELAY_QTY          16'h0004
`define MQF_EVENT_QTY          16'h0002
`define MQF_BC_EIGHT           8'h08
`define MQF_BC_FOUR            8'h04

// function codes, exception flag and exception codes
`define MQF_FN_READ_HOLD       8'h03
`define MQF_FN_RW_MULTI        8'h17
`define MQF_FN_ERR_FLAG        8'h80
`define MQF_EXC_BAD_FUNC       8'h01
`define MQF_EXC_BAD_DATA       8'h03

// frame geometry in bytes (mbap header is 7, length counts from unit id)
`define MQF_MBAP_FIXED         5'd6
`define MQF_FN3_FRAME_LEN      5'd12
`define MQF_FN17_FRAME_LEN     5'd21
`define MQF_RX_MAX             5'd21
`define MQF_LEN_GEAR           8'h0b
`define MQF_LEN_RELAY          8'h0b
`define MQF_LEN_EVENT          8'h07
`define MQF_LEN_ERROR          8'h03

// event log geometry: 128 records of two registers
`define MQF_EVENT_DEPTH_LOG2   7
`define MQF_EVENT_LAST_OFS     16'h00fe

// clock rate and led flash half period
`define MQF_CLK_KHZ            40000
`define MQF_LED_HALF_MS        250

`endif

// ### core/mqf_event_mem.v
// event record memory: one write port, registered read port
`timescale 1ns/1ps
`default_nettype none

module mqf_event_mem #(
	parameter AW = 7,
	parameter DW = 32
) (
	input  wire          clk,
	input  wire          ce,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata_r
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array; a record read before it was written shows whatever the ram holds
	always @(posedge clk) begin
		if (ce) begin
			if (we)
				mem[waddr] <= wdata;
			rdata_r <= mem[raddr];
		end
	end

endmodule // mqf_event_mem

`default_nettype wire

// ### verification/mqf_checker.sv
// checker: timing relations at the ports of the query front end
`timescale 1ns/1ps
`default_nettype none
module mqf_checker (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       ce,
	input wire logic       rx_valid,
	input wire logic       rx_last,
	input wire logic       rx_ready_r,
	input wire logic [7:0] tx_data_r,
	input wire logic       tx_valid_r,
	input wire logic       tx_last_r,
	input wire logic       tx_ready,
	input wire logic       gear_req_valid_r,
	input wire logic       gear_res_valid,
	input wire logic       usb_upg_start,
	input wire logic       led_bus_a_r,
	input wire logic       led_bus_b_r,
	input wire logic       sys_restart_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic pend_r;
	// a gear query is pending from its request pulse until the reply starts
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			pend_r <= 1'b0;
		else if (gear_req_valid_r)
			pend_r <= 1'b1;
		else if (tx_valid_r)
			pend_r <= 1'b0;
	end
	chk_rx_close: assert property (ce && rx_valid && rx_ready_r && rx_last |=> !rx_ready_r)
		else $error("intake open after last byte");
	chk_tx_hold: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r) && $stable(tx_last_r))
		else $error("reply byte changed while stalled");
	chk_gear_pulse: assert property (gear_req_valid_r |=> !gear_req_valid_r)
		else $error("gear request longer than one cycle");
	chk_gear_answer: assert property (ce && pend_r && gear_res_valid && !gear_req_valid_r |-> ##[1:3] tx_valid_r)
		else $error("no gear reply after result");
	chk_half_duplex: assert property (tx_valid_r |-> !rx_ready_r)
		else $error("intake open during reply");
	chk_reply_close: assert property (tx_valid_r && tx_ready && tx_last_r |=> !tx_valid_r ##[1:2] rx_ready_r)
		else $error("reply did not close cleanly");
	chk_led_both: assert property (!(led_bus_a_r && led_bus_b_r))
		else $error("both bus leds lit");
	chk_upg_phase: assert property (ce && usb_upg_start && (led_bus_a_r || led_bus_b_r) |=> led_bus_b_r && !led_bus_a_r)
		else $error("flash phase not restarted");
	chk_restart_dark: assert property (sys_restart_r |=> !sys_restart_r && !led_bus_a_r && !led_bus_b_r)
		else $error("restart not a dark one-cycle pulse");
	cover property (gear_req_valid_r);
	cover property (sys_restart_r);
	cover property (tx_valid_r && !tx_ready);
endmodule // mqf_checker
bind mqf_front_end mqf_checker mqf_checker_i (.clk, .nrst, .ce, .rx_valid, .rx_last, .rx_ready_r, .tx_data_r,
	.tx_valid_r, .tx_last_r, .tx_ready, .gear_req_valid_r, .gear_res_valid, .usb_upg_start, .led_bus_a_r,
	.led_bus_b_r, .sys_restart_r);
`default_nettype wire

// ### verification/mqf_client.sv
// partner model: tcp client sending one request frame and collecting the reply
`timescale 1ns/1ps
`default_nettype none
module mqf_client (
	input  wire logic       clk,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            rx_last,
	input  wire logic       rx_ready_r,
	input  wire logic [7:0] tx_data_r,
	input  wire logic       tx_valid_r,
	input  wire logic       tx_last_r,
	output logic            tx_ready
);
	logic [7:0] req [0:31];
	logic [7:0] rsp [0:31];
	int         rsp_n = 0;
	logic       hung = 1'b0;
	initial begin
		rx_data = 8'h5a;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end
	// one frame at a time, sent whole; slow mode drops tx_ready on every other clock, stalling every reply byte after the first
	task automatic xfer(input int n, input logic slow);
		int t;
		rsp_n = 0;
		@(posedge clk);
		#2;
		for (int i = 0; i < n; i++) begin
			rx_data = req[i];
			rx_valid = 1'b1;
			rx_last = (i == n - 1);
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (!rx_ready_r && t < 50);
			if (!rx_ready_r)
				hung = 1'b1;
			#2;
		end
		// released data line shows the inverse, so stale bytes are never mistaken
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
		tx_ready = 1'b1;
		t = 0;
		while (t < 200) begin
			@(posedge clk);
			t++;
			if (tx_valid_r && tx_ready && rsp_n < 32) begin
				rsp[rsp_n] = tx_data_r;
				rsp_n++;
				if (tx_last_r)
					t = 1000;
			end
			#2;
			if (slow)
				tx_ready = ~tx_ready;
		end
		if (t == 200)
			hung = 1'b1;
		tx_ready = 1'b0;
	endtask
endmodule // mqf_client
`default_nettype wire

// ### verification/mqf_front_end_tb_top.sv
// testbench: upgrade leds, relay status, event log, gear query and error replies
`timescale 1ns/1ps
`default_nettype none
module mqf_front_end_tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        set_button = 1'b1;
	logic        usb_upg_start = 1'b0;
	logic        usb_upg_done = 1'b0;
	logic        gear_res_valid = 1'b0;
	logic [63:0] gear_res_data = 64'h01010001e5000000;
	logic [3:0]  relay_closed = 4'h5;
	logic        evt_valid = 1'b0;
	logic [5:0]  evt_dev_addr = 6'h00;
	logic [7:0]  evt_inst = 8'h00;
	logic [7:0]  evt_type = 8'h00;
	logic [7:0]  evt_info = 8'h00;
	wire  [7:0]  rx_data, tx_data_r;
	wire         rx_valid, rx_last, rx_ready_r, tx_valid_r, tx_last_r, tx_ready;
	wire         gear_req_valid_r, led_bus_a_r, led_bus_b_r, sys_restart_r;
	wire  [31:0] gear_req_data_r;
	int          mismatches = 0;
	int          comparisons = 0;
	int          i;
	int          tog;
	logic        la;
	logic [15:0] a;
	logic [47:0] errs [0:4];

	always #12.5 clk = ~clk;
	// gear side answers one cycle after each query
	always @(posedge clk) gear_res_valid <= #2 gear_req_valid_r;

	mqf_front_end #(.LED_HALF_CYC(4)) mqf_front_end_i (.clk, .nrst, .ce, .rx_data, .rx_valid, .rx_last, .rx_ready_r,
		.tx_data_r, .tx_valid_r, .tx_last_r, .tx_ready, .gear_req_valid_r, .gear_req_data_r, .gear_res_valid,
		.gear_res_data, .relay_closed, .evt_valid, .evt_dev_addr, .evt_inst, .evt_type, .evt_info, .set_button,
		.usb_upg_start, .usb_upg_done, .led_bus_a_r, .led_bus_b_r, .sys_restart_r);
	mqf_client mqf_client_i (.clk, .rx_data, .rx_valid, .rx_last, .rx_ready_r, .tx_data_r, .tx_valid_r,
		.tx_last_r, .tx_ready);

	function automatic logic [31:0] ev(input int n);
		return {2'b00, n[5:0], n[7:0], n[7:0] + 8'h01, ~n[7:0]};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// send one frame, then check header echo, function and count or code, payload
	task automatic xact(input logic [167:0] f, input int n, input logic [7:0] len, input logic [15:0] fb,
			input logic [63:0] pay, input int np);
		logic [63:0] got;
		got = 64'h0;
		for (int j = 0; j < n; j++) mqf_client_i.req[j] = f[8*(n-1-j) +: 8];
		mqf_client_i.xfer(n, n[0]);
		if (mqf_client_i.hung) begin
			mismatches++;
			$display("FAIL %0t: client timed out", $time);
			test_done();
		end
		for (int j = 0; j < np; j++) got = {got[55:0], mqf_client_i.rsp[9+j]};
		chk(mqf_client_i.rsp_n, 9 + np);
		chk({mqf_client_i.rsp[0], mqf_client_i.rsp[1], mqf_client_i.rsp[2], mqf_client_i.rsp[3],
			mqf_client_i.rsp[4], mqf_client_i.rsp[5], mqf_client_i.rsp[6]}, {f[8*n-1 -: 32], 8'h00, len, 8'hff});
		chk({mqf_client_i.rsp[7], mqf_client_i.rsp[8]}, fb);
		chk(got, pay);
	endtask

	initial begin
		errs = '{48'h06_0000_0001_01, 48'h10_a029_0004_01, 48'h03_7d01_0004_03, 48'h03_80e9_0003_03,
			48'h03_84d3_0002_03};
		repeat (2) @(posedge clk);
		#2;
		chk({rx_ready_r, tx_valid_r, gear_req_valid_r, led_bus_a_r, led_bus_b_r, sys_restart_r}, 0);
		@(posedge clk);
		#2;
		nrst = 1'b1;
		// button held over reset: leds must alternate
		repeat (10) @(posedge clk);
		#2;
		tog = 0;
		la = led_bus_a_r;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			#2;
			tog += int'(led_bus_a_r !== la);
			la = led_bus_a_r;
			chk(led_bus_a_r ^ led_bus_b_r, 1);
		end
		set_button = 1'b0;
		chk(tog >= 4 && tog <= 6, 1);
		// clock enable low freezes the flash phase
		ce = 1'b0;
		la = led_bus_a_r;
		repeat (6) @(posedge clk);
		#2;
		chk({led_bus_a_r, led_bus_b_r}, {la, ~la});
		ce = 1'b1;
		usb_upg_start = 1'b1;
		@(posedge clk);
		#2;
		usb_upg_start = 1'b0;
		chk({led_bus_a_r, led_bus_b_r}, 2'b01);
		repeat (5) @(posedge clk);
		#2;
		usb_upg_done = 1'b1;
		@(posedge clk);
		#2;
		usb_upg_done = 1'b0;
		chk(sys_restart_r, 1);
		repeat (12) begin
			@(posedge clk);
			#2;
			chk({led_bus_a_r, led_bus_b_r, sys_restart_r}, 0);
		end
		xact({16'h0003, 80'h0000_0006_ff03_80e9_0004}, 12, 8'h0b, 16'h0308, 64'h0100000001000000, 8);
		// 130 events wrap the 128-record log over its first two slots
		for (i = 0; i < 130; i++) begin
			{evt_dev_addr, evt_inst, evt_type, evt_info} = 30'(ev(i));
			evt_valid = 1'b1;
			@(posedge clk);
			#2;
			evt_valid = 1'b0;
			@(posedge clk);
			#2;
		end
		for (i = 0; i < 4; i++) begin
			tog = (i == 3) ? 127 : i;
			a = 16'h84d2 + 16'(2 * tog);
			xact({16'h0004, 48'h0000_0006_ff03, a, 16'h0002}, 12, 8'h07, 16'h0304, ev(tog < 2 ? tog + 128 : tog), 4);
		end
		xact(168'h00010000000fff177d010004a41100020401010001, 21, 8'h0b, 16'h1708, gear_res_data, 8);
		chk(gear_req_data_r, 32'h01010001);
		for (i = 0; i < 5; i++)
			xact({16'h0005, 40'h0000_0006_ff, errs[i][47:8]}, 12, 8'h03, {errs[i][47:40] | 8'h80, errs[i][7:0]}, 0, 0);
		test_done();
	end
endmodule // mqf_front_end_tb_top
`default_nettype wire
